// ### rtl/sdadc_pkg.sv
/*
 * Constants and types shared by the delta-sigma converter mode control.
 * Assumes nothing of its surroundings; pure definitions.
 */
package sdadc_pkg;

  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [1:0] {
    SDADC_MODE_PDN   = 2'b00,
    SDADC_MODE_SLEEP = 2'b01,
    SDADC_MODE_NORM  = 2'b10,
    SDADC_MODE_RST   = 2'b11
  } sdadc_mode_e;

  // ****************************************
  // Clock and rate constants
  // ****************************************
  localparam logic [4:0] SDADC_CLKDIV_BYPASS = 5'h1F;
  localparam int SDADC_MCLK_PRE = 2;
  localparam logic [6:0] SDADC_ADCK_DIV_LONG = 7'h1E;
  localparam logic [6:0] SDADC_ADCK_DIV_SHORT = 7'h0C;
  localparam int SDADC_FLMS_RATE_BIT = 1;
  localparam int SDADC_FLMS_CHOP_BIT = 2;
  localparam logic [15:0] SDADC_OSR_MAX = 16'h4000;
  localparam int SDADC_CONV_W = 16;
  localparam int SDADC_DATA_W = 24;

  // ****************************************
  // Reset values and default sensor channel
  // ****************************************
  localparam logic [SDADC_DATA_W-1:0] SDADC_DATA_RST = 24'h000000;
  localparam logic [3:0] SDADC_TSENSE_CH_DEF = 4'hF;

endpackage

// ### rtl/sdadc_tick_div.sv
/*
 * Programmable divider producing a one-cycle enable pulse every div_in
 * enabled input cycles. Assumes div_in is at least 1 and is static
 * while counting; a change restarts cleanly at the next wrap.
 */
`timescale 1ns/10ps
`default_nettype none

module sdadc_tick_div
#(
  parameter int W = 7
)
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Control
  input wire logic run_in,
  input wire logic en_in,
  input wire logic [W-1:0] div_in,
  // Output pulse
  output logic tick_out
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic wrap;

  // ****************************************
  // Count decode
  // ****************************************
  assign wrap = en_in && (cnt_r >= div_in - W'(1));
  assign cnt_nxt = !run_in ? '0 : wrap ? '0 : en_in ? cnt_r + W'(1) : cnt_r;

  // Counter and registered pulse
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      cnt_r <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_out <= run_in && wrap;
    end
  end

endmodule
`default_nettype wire

// ### rtl/sdadc_mode_ctrl.sv
/*
 * Mode control of a delta-sigma converter: decodes power-off, sleep and
 * filter-reset bits into analog enables, times conversions from the
 * system clock, and keeps the end-of-conversion flag, interrupt request
 * and result bytes. Assumes all control bits come from registers on
 * sys_clk_in; result_data_in is the filter output valid at conversion end.
 */
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Four modes from power-off, sleep, filter-reset
// - Power-off forces power down, all disabled but bandgap, common-mode, regulator
// - Common-mode follows bandgap; regulator bit in power-down
// - Sleep: modulator, sensor, buffers off; regulator follows its bit; rest on
// - Filter-reset holds filter in reset, else normal
// - Reset bit pulse high-low starts conversions
// - Sensor enable from channel selects in run modes
// - Each reference buffer has own enable bit
// - Conversion end sets end-of-conversion flag
// - Conversion end sets interrupt request flag
// - Interrupt needs global and converter enables
// - Results overwrite data while hold is off
// - Hold keeps last result, discards new ones
// - Reference select picks reference pair
// - Data rate from oversampling and filter mode
// - Hold suppresses flag and interrupt, keeps converting
// - Oversampling 16384 halving down to 128
// - Clock divider sys/2/(n+1), 11111 bypass
module sdadc_mode_ctrl
  import sdadc_pkg::*;
#(
  parameter logic [3:0] TSENSE_CH = SDADC_TSENSE_CH_DEF
)
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Mode control bits
  input wire logic regulator_enable_in,
  input wire logic conv_power_off_in,
  input wire logic conv_sleep_in,
  input wire logic filter_reset_in,
  // Configuration
  input wire logic result_hold_enable_in,
  input wire logic reference_select_in,
  input wire logic [4:0] clock_divider_field_in,
  input wire logic [2:0] oversampling_field_in,
  input wire logic [2:0] filter_mode_field_in,
  input wire logic [3:0] positive_channel_select_in,
  input wire logic [3:0] negative_channel_select_in,
  input wire logic neg_ref_buffer_enable_in,
  input wire logic pos_ref_buffer_enable_in,
  // Interrupt control
  input wire logic global_interrupt_enable_in,
  input wire logic converter_interrupt_enable_in,
  input wire logic eoc_clear_in,
  input wire logic irq_flag_clear_in,
  // Filter data
  input wire logic [SDADC_DATA_W-1:0] result_data_in,
  // Analog enables
  output logic [1:0] mode_out,
  output logic bandgap_en_out,
  output logic regulator_en_out,
  output logic vcm_en_out,
  output logic amp_en_out,
  output logic modulator_en_out,
  output logic tsense_en_out,
  output logic neg_ref_buf_en_out,
  output logic pos_ref_buf_en_out,
  output logic sinc_en_out,
  output logic sinc_reset_out,
  output logic ref_select_out,
  // Timing
  output logic mclk_tick_out,
  output logic converting_out,
  // Status and results
  output logic eoc_out,
  output logic irq_flag_out,
  output logic int_req_out,
  output logic [7:0] result_low_byte_out,
  output logic [7:0] result_mid_byte_out,
  output logic [7:0] result_high_byte_out
);

  // ****************************************
  // Mode decode
  // ****************************************
  sdadc_mode_e mode_nxt;
  logic run_mode;
  logic bandgap_nxt;

  // Power-off dominates, then sleep, then the filter-reset bit
  assign mode_nxt = conv_power_off_in ? SDADC_MODE_PDN :
                    conv_sleep_in ? SDADC_MODE_SLEEP :
                    filter_reset_in ? SDADC_MODE_RST : SDADC_MODE_NORM;
  assign run_mode = (mode_nxt == SDADC_MODE_NORM) || (mode_nxt == SDADC_MODE_RST);
  assign bandgap_nxt = !conv_power_off_in || regulator_enable_in;

  // Temperature sensor follows the channel selects, gated by the run modes
  logic tsense_sel;
  assign tsense_sel = (positive_channel_select_in == TSENSE_CH) ||
                      (negative_channel_select_in == TSENSE_CH);

  // Registered analog enables; one cycle of latency on every mode change
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      mode_out <= SDADC_MODE_PDN;
      bandgap_en_out <= 1'b0;
      regulator_en_out <= 1'b0;
      vcm_en_out <= 1'b0;
      amp_en_out <= 1'b0;
      modulator_en_out <= 1'b0;
      tsense_en_out <= 1'b0;
      neg_ref_buf_en_out <= 1'b0;
      pos_ref_buf_en_out <= 1'b0;
      sinc_en_out <= 1'b0;
      sinc_reset_out <= 1'b0;
      ref_select_out <= 1'b0;
    end
    else
    begin
      mode_out <= mode_nxt;
      bandgap_en_out <= bandgap_nxt;
      regulator_en_out <= regulator_enable_in;
      vcm_en_out <= bandgap_nxt;
      amp_en_out <= !conv_power_off_in;
      modulator_en_out <= run_mode;
      tsense_en_out <= run_mode && tsense_sel;
      neg_ref_buf_en_out <= run_mode && neg_ref_buffer_enable_in;
      pos_ref_buf_en_out <= run_mode && pos_ref_buffer_enable_in;
      sinc_en_out <= !conv_power_off_in;
      sinc_reset_out <= mode_nxt == SDADC_MODE_RST;
      ref_select_out <= reference_select_in;
    end
  end

  // ****************************************
  // Start detection
  // ****************************************
  logic frst_d_r;
  logic start_pulse;
  logic running_r;
  logic running_nxt;

  // Falling edge of the reset bit in a run mode closes the high-low pulse
  assign start_pulse = frst_d_r && !filter_reset_in && run_mode;
  assign running_nxt = conv_power_off_in || filter_reset_in ? 1'b0 :
                       start_pulse ? 1'b1 : running_r;

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      frst_d_r <= 1'b0;
      running_r <= 1'b0;
    end
    else
    begin
      frst_d_r <= filter_reset_in;
      running_r <= running_nxt;
    end
  end

  // ****************************************
  // Clock dividers and conversion timing
  // ****************************************
  logic [6:0] mclk_div;
  logic [6:0] adck_div;
  logic adck_tick;
  logic mclk_tick;
  logic counting;
  logic [SDADC_CONV_W-1:0] osr;
  logic [SDADC_CONV_W-1:0] conv_len;
  logic [SDADC_CONV_W-1:0] conv_cnt_r;
  logic conv_end;

  // Bypass code runs the converter clock at the system rate
  assign mclk_div = (clock_divider_field_in == SDADC_CLKDIV_BYPASS) ? 7'h01 :
                    7'(SDADC_MCLK_PRE * (int'(clock_divider_field_in) + 1));
  assign adck_div = filter_mode_field_in[SDADC_FLMS_RATE_BIT] ? SDADC_ADCK_DIV_SHORT
                                                              : SDADC_ADCK_DIV_LONG;
  assign osr = SDADC_OSR_MAX >> oversampling_field_in;
  // A clear chop bit doubles the samples per result; chop mode does not
  assign conv_len = filter_mode_field_in[SDADC_FLMS_CHOP_BIT] ? osr
                                                              : SDADC_CONV_W'(osr << 1);
  // Sleep stops the modulator, so conversions pause but are not lost
  assign counting = running_r && run_mode;

  sdadc_tick_div #(.W(7)) u_mclk_div (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .run_in(counting),
    .en_in(1'b1),
    .div_in(mclk_div),
    .tick_out(mclk_tick)
  );

  sdadc_tick_div #(.W(7)) u_adck_div (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .run_in(counting),
    .en_in(mclk_tick),
    .div_in(adck_div),
    .tick_out(adck_tick)
  );

  assign conv_end = counting && adck_tick && (conv_cnt_r >= conv_len - SDADC_CONV_W'(1));

  // Conversions continue back to back once started
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      conv_cnt_r <= '0;
    else if (!running_r)
      conv_cnt_r <= '0;
    else if (conv_end)
      conv_cnt_r <= '0;
    else if (counting && adck_tick)
      conv_cnt_r <= conv_cnt_r + SDADC_CONV_W'(1);
  end

  // ****************************************
  // Flags, interrupt and results
  // ****************************************
  logic accept;
  assign accept = conv_end && !result_hold_enable_in;

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      eoc_out <= 1'b0;
      irq_flag_out <= 1'b0;
      int_req_out <= 1'b0;
      mclk_tick_out <= 1'b0;
      converting_out <= 1'b0;
    end
    else
    begin
      eoc_out <= accept || (eoc_out && !eoc_clear_in);
      irq_flag_out <= accept || (irq_flag_out && !irq_flag_clear_in);
      int_req_out <= irq_flag_out && global_interrupt_enable_in && converter_interrupt_enable_in;
      mclk_tick_out <= mclk_tick;
      converting_out <= counting;
    end
  end

  // Result registers update only when the hold is off
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      {result_high_byte_out, result_mid_byte_out, result_low_byte_out} <= SDADC_DATA_RST;
    else if (accept)
      {result_high_byte_out, result_mid_byte_out, result_low_byte_out} <= result_data_in;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_pdn_gates_off: assert property ($past(conv_power_off_in) |->
    !amp_en_out && !modulator_en_out && !tsense_en_out && !sinc_en_out
    && !neg_ref_buf_en_out && !pos_ref_buf_en_out && mode_out == SDADC_MODE_PDN)
    else $error("power down left a block enabled");
  a_vcm_follow_bg: assert property (vcm_en_out == bandgap_en_out
    and ($past(conv_power_off_in) |-> bandgap_en_out == $past(regulator_enable_in)))
    else $error("common-mode or bandgap wrong");
  a_sleep_gates: assert property ($past(!conv_power_off_in && conv_sleep_in) |->
    !modulator_en_out && !tsense_en_out && amp_en_out && sinc_en_out && bandgap_en_out)
    else $error("sleep enables wrong");
  a_reset_holds_sinc: assert property ($past(!conv_power_off_in && !conv_sleep_in) |->
    sinc_reset_out == $past(filter_reset_in) && modulator_en_out)
    else $error("filter reset state wrong");
  a_start_pulse_run: assert property (start_pulse && !conv_power_off_in |=> running_r)
    else $error("start pulse did not start conversions");
  a_buf_enables: assert property ($past(run_mode) |->
    pos_ref_buf_en_out == $past(pos_ref_buffer_enable_in)
    && neg_ref_buf_en_out == $past(neg_ref_buffer_enable_in))
    else $error("reference buffer enable wrong");
  a_eoc_set_end: assert property (accept |=> eoc_out && irq_flag_out)
    else $error("conversion end did not set flags");
  a_eoc_sticky: assert property (eoc_out && !eoc_clear_in |=> eoc_out)
    else $error("end flag cleared without software");
  a_hold_no_flag: assert property ($rose(eoc_out) || $rose(irq_flag_out) |-> $past(conv_end && !result_hold_enable_in))
    else $error("flag rose without accepted result");
  a_hold_keeps_data: assert property (result_hold_enable_in |=> $stable(result_low_byte_out)
    && $stable(result_mid_byte_out) && $stable(result_high_byte_out))
    else $error("held result changed");
  a_int_gate: assert property (int_req_out |-> $past(irq_flag_out && global_interrupt_enable_in
    && converter_interrupt_enable_in))
    else $error("interrupt without both enables");
  a_mclk_bypass: assert property (counting && clock_divider_field_in == SDADC_CLKDIV_BYPASS
    && $past(counting) && $past(clock_divider_field_in) == SDADC_CLKDIV_BYPASS |-> mclk_tick)
    else $error("bypass clock missed a cycle");

  c_conv_end: cover property (accept);
  c_hold_discard: cover property (conv_end && result_hold_enable_in);
  c_sleep_entry: cover property (mode_out == SDADC_MODE_NORM ##1 mode_out == SDADC_MODE_SLEEP);
  c_set_clear_clash: cover property (accept && eoc_clear_in);

endmodule
`default_nettype wire

// ### bench/tb.sv
/*
 * Self-checking bench for the converter mode control: a table of mode rows,
 * then conversion timing, result hold, interrupt gating, stop and reset.
 * Assumes the design holds its own assertions and the default TSENSE_CH.
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
  import sdadc_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic reg_en = 1'b0, off = 1'b1, slp = 1'b0, frst = 1'b0, hold = 1'b0, refs = 1'b0;
  logic [4:0] div = 5'h1F;
  logic [2:0] osr = 3'h7, fm = 3'h6;
  logic [3:0] pch = 4'h0, nch = 4'h0;
  logic nbuf = 1'b0, pbuf = 1'b0, gie = 1'b0, cie = 1'b0, eclr = 1'b0, iclr = 1'b0;
  logic [23:0] din = 24'hA5C3E1;
  logic [1:0] mode;
  logic bg, rg, vcm, amp, modu, ts, nb, pb, se, sr, rsel, tick, conv, eoc, irqf, intr;
  logic [7:0] lo, mi, hi;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic [20:0] rows [8];
  logic [12:0] seen, mask;

  sdadc_mode_ctrl sdadc_mode_ctrl_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .regulator_enable_in(reg_en), .conv_power_off_in(off), .conv_sleep_in(slp), .filter_reset_in(frst),
    .result_hold_enable_in(hold), .reference_select_in(refs), .clock_divider_field_in(div),
    .oversampling_field_in(osr), .filter_mode_field_in(fm), .positive_channel_select_in(pch),
    .negative_channel_select_in(nch), .neg_ref_buffer_enable_in(nbuf), .pos_ref_buffer_enable_in(pbuf),
    .global_interrupt_enable_in(gie), .converter_interrupt_enable_in(cie), .eoc_clear_in(eclr),
    .irq_flag_clear_in(iclr), .result_data_in(din), .mode_out(mode), .bandgap_en_out(bg),
    .regulator_en_out(rg), .vcm_en_out(vcm), .amp_en_out(amp), .modulator_en_out(modu),
    .tsense_en_out(ts), .neg_ref_buf_en_out(nb), .pos_ref_buf_en_out(pb), .sinc_en_out(se),
    .sinc_reset_out(sr), .ref_select_out(rsel), .mclk_tick_out(tick), .converting_out(conv),
    .eoc_out(eoc), .irq_flag_out(irqf), .int_req_out(intr), .result_low_byte_out(lo),
    .result_mid_byte_out(mi), .result_high_byte_out(hi));

  // ****************************************
  // Clock, cycle ceiling and shared tasks
  // ****************************************
  // Half period of 4 ns gives 125 MHz
  always #4 sys_clk_in = ~sys_clk_in;

  // Ceiling well above the roughly 17000 cycles the sequence needs
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      errors++;
      conclude();
    end
  end

  task automatic check(input string name, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Bounded wait on the end flag; returns the negedges waited
  task automatic wait_eoc(output int k);
    k = 0;
    while (eoc !== 1'b1 && k < 4000)
    begin
      @(negedge sys_clk_in);
      k++;
    end
  endtask

  // Clears both flags for one cycle, then waits for the next end
  task automatic measure(output int k);
    eclr = 1'b1;
    iclr = 1'b1;
    @(negedge sys_clk_in);
    eclr = 1'b0;
    iclr = 1'b0;
    wait_eoc(k);
  endtask

  // Cycles from the current master tick to the next one
  task automatic gap(output int g);
    @(negedge sys_clk_in);
    g = 1;
    while (tick !== 1'b1 && g < 200)
    begin
      @(negedge sys_clk_in);
      g++;
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    // Inputs: reg,off,slp,rst,tsense-chan,nbuf,pbuf,ref; outputs: mode,bg,reg,vcm,amp,mod,ts,nb,pb,se,sr,ref
    rows = '{{8'h7F, 13'h0001}, {8'hC6, 13'h0700}, {8'h2F, 13'h0D85}, {8'hB0, 13'h0F84},
             {8'h0A, 13'h15EC}, {8'h85, 13'h17D5}, {8'h1E, 13'h1DFA}, {8'h90, 13'h1FC2}};
    repeat (19) @(negedge sys_clk_in);
    check("reset_state", {mode, eoc, irqf, conv, hi}, 0);
    @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    // Mode table: one edge from inputs to enables
    foreach (rows[i])
    begin
      {reg_en, off, slp, frst} = rows[i][20:17];
      // Sensor routed by the positive select first, later by the negative one
      pch = (rows[i][16] && i < 5) ? 4'hF : 4'h0;
      nch = (rows[i][16] && i >= 5) ? 4'hF : 4'h0;
      {nbuf, pbuf, refs} = rows[i][15:13];
      @(negedge sys_clk_in);
      seen = {mode, bg, rg, vcm, amp, modu, ts, nb, pb, se, sr, rsel};
      // Filter enable is left open while the filter is held in reset
      mask = (rows[i][12:11] == 2'h3) ? 13'h1FFB : 13'h1FFF;
      check("mode_row", seen & mask, rows[i][12:0] & mask);
    end
    // Power up with the fastest settings, drop the filter reset left high by the last row
    {off, slp, frst, gie, cie, eclr, iclr} = 7'h0F;
    @(negedge sys_clk_in);
    {frst, eclr, iclr} = 3'h0;
    repeat (1400) @(negedge sys_clk_in);
    check("eoc_in_progress", {eoc, irqf}, 0);
    wait_eoc(n);
    check("first_end", n < 4000, 1);
    check("result_bytes", {hi, mi, lo}, 24'hA5C3E1);
    check("irq_flag_set", irqf, 1);
    @(negedge sys_clk_in);
    check("int_req", intr, 1);
    din = 24'h3C5A96;
    measure(n);
    // Count starts two cycles after the previous end: 1 x 12 x 128 cycles
    check("period_chop1", n, 12 * 128 - 2);
    check("result_next", {hi, mi, lo}, 24'h3C5A96);
    fm = 3'h2;
    measure(n);
    measure(n);
    check("period_chop2", n, 3071);
    fm = 3'h6;
    measure(n);
    // Hold: conversions continue but nothing is reported
    hold = 1'b1;
    din = 24'h1E2D4B;
    measure(n);
    check("hold_no_eoc", {eoc, irqf, conv}, 3'h1);
    check("hold_bytes", {hi, mi, lo}, 24'h3C5A96);
    gie = 1'b0;
    hold = 1'b0;
    wait_eoc(n);
    check("release_bytes", {hi, mi, lo}, 24'h1E2D4B);
    repeat (2) @(negedge sys_clk_in);
    check("int_masked", {irqf, intr}, 2'h2);
    gie = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    check("int_unmasked", intr, 1);
    // Clear lands on the edge of the next end: the set wins
    repeat (1531) @(negedge sys_clk_in);
    eclr = 1'b1;
    @(negedge sys_clk_in);
    eclr = 1'b0;
    check("set_wins", {eoc, irqf}, 2'h3);
    // Master tick spacing for several divider codes; 0F is near 4 MHz
    foreach (rows[i])
    begin
      if (i < 5)
      begin
        div = (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : (i == 2) ? 5'h05 : (i == 3) ? 5'h0F : 5'h1F;
        repeat (3) gap(n);
        gap(n);
        check("tick_gap", n, (div == 5'h1F) ? 1 : 2 * (div + 1));
      end
    end
    // Sleep pauses conversions without cancelling them
    slp = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    check("sleep_pause", {mode, conv, modu, amp}, 5'h09);
    slp = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    check("sleep_resume", {mode, conv}, 3'h5);
    // Power off stops conversions; power on alone does not restart
    off = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    check("off_stop", {mode, conv, modu, se}, 0);
    off = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    check("no_restart", {mode, conv}, 3'h4);
    // Reset in mid-run clears flags and results
    rst_b_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    check("mid_reset", {eoc, irqf, intr, hi, mi, lo, mode}, 0);
    conclude();
  end
endmodule

`default_nettype wire
